/* design/rgt_pkg.sv */
// Package with constants and types of the reading gate trigger.
package rgt_pkg;
   localparam int unsigned RGT_CLK_HZ = 200_000_000;
   localparam int unsigned RGT_POLL_SCANS = 20;
   localparam logic [4:0] RGT_POLL_LAST = 5'(RGT_POLL_SCANS - 1);
   localparam int unsigned RGT_POLL_DELAY_MS = 25;
   localparam int unsigned RGT_POLL_RATE_HZ = 800;
   localparam int unsigned RGT_POLL_DELAY_SCANS = (RGT_POLL_DELAY_MS * RGT_POLL_RATE_HZ) / 1000;
   localparam int unsigned RGT_OSC_FREQ_HZ = 1;
   localparam int unsigned RGT_OSC_PERIOD_CYC = RGT_CLK_HZ / RGT_OSC_FREQ_HZ;
   localparam int unsigned RGT_TONE_MS = 100;
   localparam int unsigned RGT_TONE_CYC = (RGT_CLK_HZ / 1000) * RGT_TONE_MS;
   localparam logic [7:0] RGT_MIRROR_CENTER = 8'h32;
   localparam logic [7:0] RGT_MIRROR_AMPL = 8'h14;
   localparam logic [11:0] RGT_ADDR_CTRL = 12'h000;
   localparam logic [11:0] RGT_ADDR_GATES = 12'h004;
   localparam logic [11:0] RGT_ADDR_STATUS = 12'h008;
   localparam int unsigned RGT_CTRL_MODE_LSB = 0;
   localparam int unsigned RGT_CTRL_OSC_BIT = 2;
   localparam logic [1:0] RGT_CTRL_MODE_RST = 2'h0;
   localparam logic RGT_CTRL_OSC_RST = 1'b1;
   typedef enum logic [1:0]
   {
      RGT_MODE_SENSOR = 2'b00,
      RGT_MODE_REFLECTOR = 2'b01
   } rgt_mode_e;
   typedef enum logic [1:0]
   {
      RGT_RS_UNSEEN = 2'b00,
      RGT_RS_ARMED = 2'b01,
      RGT_RS_GATE = 2'b10
   } rgt_refl_e;
endpackage

/* design/rgt_mirror.sv */
// Scan mirror oscillation around its centre position.
`timescale 1ns/1ps
`default_nettype none
module rgt_mirror
#(
   parameter int unsigned PERIOD_CYC = 200_000_000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_en,
   output logic [7:0] mirror_angle_position
);
   import rgt_pkg::*;
   localparam int unsigned STEP_CYC = (PERIOD_CYC / (4 * 20) > 0) ? PERIOD_CYC / (4 * 20) : 1;
   logic [31:0] step_cnt_r;
   logic dir_up_r;
   logic [7:0] pos_r;
   assign mirror_angle_position = pos_r;
   // One full triangle takes four amplitude sweeps, so the step is a quarter period over the amplitude.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         step_cnt_r <= 32'h0;
         dir_up_r <= 1'b1;
         pos_r <= RGT_MIRROR_CENTER;
      end
      else if (!osc_en)
      begin
         step_cnt_r <= 32'h0;
         dir_up_r <= 1'b1;
         pos_r <= RGT_MIRROR_CENTER;
      end
      else if (step_cnt_r == 32'(STEP_CYC - 1))
      begin
         step_cnt_r <= 32'h0;
         if (dir_up_r && pos_r == RGT_MIRROR_CENTER + RGT_MIRROR_AMPL)
         begin
            dir_up_r <= 1'b0;
            pos_r <= pos_r - 8'h01;
         end
         else if (!dir_up_r && pos_r == RGT_MIRROR_CENTER - RGT_MIRROR_AMPL)
         begin
            dir_up_r <= 1'b1;
            pos_r <= pos_r + 8'h01;
         end
         else
            pos_r <= dir_up_r ? pos_r + 8'h01 : pos_r - 8'h01;
      end
      else
         step_cnt_r <= step_cnt_r + 32'h1;
   end
   chk_mirror_bounds: assert property (@(posedge pclk) disable iff (!presetn)
      pos_r >= RGT_MIRROR_CENTER - RGT_MIRROR_AMPL && pos_r <= RGT_MIRROR_CENTER + RGT_MIRROR_AMPL)
      else $error("Mirror position left its swing.");
endmodule // rgt_mirror
`default_nettype wire

/* design/rgt_powerup.sv */
// Power-up tone sequence and ready indication.
`timescale 1ns/1ps
`default_nettype none
module rgt_powerup
#(
   parameter int unsigned TONE_CYC = 20_000_000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic selftest_pass,
   output logic beep,
   output logic ready
);
   import rgt_pkg::*;
   logic [2:0] step_r;
   logic [31:0] cnt_r;
   // Steps: 0 wait, 1 tone, 2 gap, 3 tone, 4 gap, 5 tone, 6 ready.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         step_r <= 3'h0;
         cnt_r <= 32'h0;
      end
      else if (step_r == 3'h0)
      begin
         if (selftest_pass)
            step_r <= 3'h1;
      end
      else if (step_r != 3'h6)
      begin
         if (cnt_r == 32'(TONE_CYC - 1))
         begin
            cnt_r <= 32'h0;
            step_r <= step_r + 3'h1;
         end
         else
            cnt_r <= cnt_r + 32'h1;
      end
   end
   assign beep = (step_r == 3'h1) || (step_r == 3'h3) || (step_r == 3'h5);
   assign ready = (step_r == 3'h6);
   chk_ready_after_tone: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ready) |-> $past(step_r) == 3'h5)
      else $error("Ready rose without the last tone.");
endmodule // rgt_powerup
`default_nettype wire

/* design/rgt_trigger.sv */
// Reading gate trigger with sensor and reflector polling sources and APB registers.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - By default the first switching input opens and closes the reading gate.
// - After self-test: one tone, then two tones, then ready indicator on.
// - Oscillating mirror swings around position 50 at 1 Hz, at most 20 degrees.
// - Level trigger opens the gate while the first input is high.
// - Reflector mode lights the laser every 20th scan to look for the target.
// - Target still seen means another 20 scans before the next check.
// - A check missing the hidden target opens the reading gate.
// - Reflector gate closes when the target is seen again; polling resumes.
// - After power-up no reflector gate before the target was seen once.
// - Target code contents are never reported as a reading result.
// - Check-to-gate delay stays within about 25 ms at 800 Hz scanning.
// - Reflector polling is off by default and only on when selected.
// - With oscillation every loss of the target starts a new gate; the code opens one only for a loss seen at a polling scan.
module rgt_trigger
#(
   parameter int unsigned OSC_PERIOD_CYC = rgt_pkg::RGT_OSC_PERIOD_CYC,
   parameter int unsigned TONE_CYC = rgt_pkg::RGT_TONE_CYC,
   parameter int unsigned RESULT_W = 32
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic selftest_pass,
   input wire logic scan_tick,
   input wire logic sensor1_in,
   input wire logic target_seen,
   input wire logic decode_valid,
   input wire logic decode_is_target,
   input wire logic [RESULT_W-1:0] decode_data,
   output logic reading_gate,
   output logic laser_en,
   output logic result_valid,
   output logic [RESULT_W-1:0] result_data,
   output logic beep,
   output logic ready_led,
   output logic [7:0] mirror_angle_position
);
   import rgt_pkg::*;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == RGT_ADDR_CTRL) || (a == RGT_ADDR_GATES) || (a == RGT_ADDR_STATUS);
   endfunction

   // The opening condition feeds both the gate and the opening counter, so it is decoded once here.
   function automatic logic refl_open(input rgt_refl_e st, input logic poll, input logic seen);
      refl_open = (st == RGT_RS_ARMED) && poll && !seen;
   endfunction

   logic [1:0] mode_r;
   logic osc_en_r;
   logic [31:0] prdata_r;
   logic err_r;
   logic gate_r;
   logic seen_once_r;
   logic [4:0] scan_cnt_r;
   logic [15:0] gates_r;
   logic result_valid_r;
   logic [RESULT_W-1:0] result_data_r;
   rgt_refl_e refl_r;
   logic ready;
   logic refl_mode;
   logic poll_scan;
   logic setup;
   logic wr_access;

   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite && pready;
   assign refl_mode = (mode_r == RGT_MODE_REFLECTOR) && ready;
   assign poll_scan = (scan_cnt_r == RGT_POLL_LAST);
   // The indicator simply mirrors the end of the power-up sequence.
   assign ready_led = ready;

   rgt_powerup #(.TONE_CYC(TONE_CYC)) u_powerup
   (
      .pclk(pclk),
      .presetn(presetn),
      .selftest_pass(selftest_pass),
      .beep(beep),
      .ready(ready)
   );

   rgt_mirror #(.PERIOD_CYC(OSC_PERIOD_CYC)) u_mirror
   (
      .pclk(pclk),
      .presetn(presetn),
      .osc_en(osc_en_r && ready),
      .mirror_angle_position(mirror_angle_position)
   );

   // The answer is prepared in the setup cycle, so every access completes without wait states.
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = psel && penable && err_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h0;
         err_r <= 1'b0;
      end
      else if (setup)
      begin
         err_r <= !addr_known(paddr);
         unique case (paddr)
            RGT_ADDR_CTRL: prdata_r <= {29'h0, osc_en_r, mode_r};
            RGT_ADDR_GATES: prdata_r <= {16'h0, gates_r};
            RGT_ADDR_STATUS: prdata_r <= {19'h0, mirror_angle_position, refl_r, seen_once_r, ready, gate_r};
            default: prdata_r <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= RGT_CTRL_MODE_RST;
         osc_en_r <= RGT_CTRL_OSC_RST;
      end
      else if (wr_access && paddr == RGT_ADDR_CTRL)
      begin
         mode_r <= pwdata[RGT_CTRL_MODE_LSB +: 2];
         osc_en_r <= pwdata[RGT_CTRL_OSC_BIT];
      end
   end

   // Scan counter: the 20th scan of each group is the polling scan.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         scan_cnt_r <= 5'h0;
      else if (!refl_mode || refl_r == RGT_RS_GATE)
         scan_cnt_r <= 5'h0;
      else if (scan_tick)
         scan_cnt_r <= poll_scan ? 5'h0 : scan_cnt_r + 5'h01;
   end

   // Reflector state; a result is taken from the target input at the end of a polling scan, and of every scan while the gate is open.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         refl_r <= RGT_RS_UNSEEN;
      else if (!refl_mode)
         refl_r <= RGT_RS_UNSEEN;
      else if (scan_tick)
      begin
         unique case (refl_r)
            RGT_RS_UNSEEN:
            begin
               if (poll_scan && target_seen)
                  refl_r <= RGT_RS_ARMED;
            end
            RGT_RS_ARMED:
            begin
               if (poll_scan && !target_seen)
                  refl_r <= RGT_RS_GATE;
            end
            RGT_RS_GATE:
            begin
               if (target_seen)
                  refl_r <= RGT_RS_ARMED;
            end
            default: refl_r <= RGT_RS_UNSEEN;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seen_once_r <= 1'b0;
      else if (!refl_mode)
         seen_once_r <= 1'b0;
      else if (scan_tick && poll_scan && target_seen)
         seen_once_r <= 1'b1;
   end

   // Gate level changes only at scan ticks so downstream logic sees it stable for a whole scan.
   // With the mirror swinging, a sweep off the target opens a fresh gate only if it covers a polling scan.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_r <= 1'b0;
      else if (!ready)
         gate_r <= 1'b0;
      else if (scan_tick)
      begin
         if (refl_mode)
            gate_r <= refl_open(refl_r, poll_scan, target_seen) ||
                      (refl_r == RGT_RS_GATE && !target_seen);
         else
            gate_r <= sensor1_in;
      end
   end
   assign reading_gate = gate_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gates_r <= 16'h0;
      else if (scan_tick && !gate_r && reading_gate_nxt_open())
         gates_r <= gates_r + 16'h0001;
   end

   function automatic logic reading_gate_nxt_open();
      if (!ready)
         reading_gate_nxt_open = 1'b0;
      else if (refl_mode)
         reading_gate_nxt_open = refl_open(refl_r, poll_scan, target_seen);
      else
         reading_gate_nxt_open = sensor1_in;
   endfunction

   // Laser burns throughout a gate, and outside it only on polling scans.
   assign laser_en = gate_r || (refl_mode && refl_r != RGT_RS_GATE && poll_scan);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_valid_r <= 1'b0;
         result_data_r <= '0;
      end
      else
      begin
         result_valid_r <= decode_valid && gate_r && !decode_is_target;
         if (decode_valid && !decode_is_target)
            result_data_r <= decode_data;
      end
   end
   assign result_valid = result_valid_r;
   assign result_data = result_data_r;

   chk_sensor_level: assert property (@(posedge pclk) disable iff (!presetn)
      $past(scan_tick) && $past(ready) && $past(mode_r) == RGT_MODE_SENSOR |-> gate_r == $past(sensor1_in))
      else $error("Gate does not follow the sensor level.");
   chk_gate_at_tick: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(gate_r) |-> $past(scan_tick))
      else $error("Gate opened between scan ticks.");
   chk_target_suppress: assert property (@(posedge pclk) disable iff (!presetn)
      result_valid_r |-> !$past(decode_is_target) && $past(decode_valid))
      else $error("Target code reported as a result.");
   chk_poll_laser: assert property (@(posedge pclk) disable iff (!presetn)
      laser_en && !gate_r |-> scan_cnt_r == RGT_POLL_LAST && refl_mode)
      else $error("Laser lit outside a polling scan.");
   chk_first_seen: assert property (@(posedge pclk) disable iff (!presetn)
      refl_mode && !seen_once_r |-> refl_r == RGT_RS_UNSEEN && !(gate_r && mode_r == RGT_MODE_REFLECTOR))
      else $error("Reflector gate before first target sighting.");
   chk_close_on_target: assert property (@(posedge pclk) disable iff (!presetn)
      refl_mode && refl_r == RGT_RS_GATE && scan_tick && target_seen |=> !gate_r ##0 refl_r == RGT_RS_ARMED)
      else $error("Gate did not close on target.");
   chk_open_on_loss: assert property (@(posedge pclk) disable iff (!presetn)
      refl_mode && refl_r == RGT_RS_ARMED && scan_tick && poll_scan && !target_seen |=> gate_r)
      else $error("Hidden target did not open the gate.");
   chk_refl_default_off: assert property (@(posedge pclk) disable iff (!presetn)
      mode_r != RGT_MODE_REFLECTOR |=> refl_r == RGT_RS_UNSEEN)
      else $error("Reflector polling active without selection.");
   chk_recheck_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      refl_mode && refl_r == RGT_RS_ARMED && scan_tick && poll_scan && target_seen |=> scan_cnt_r == 5'h0)
      else $error("Next check not 20 scans away.");

   // Gate timing and laser use.
   chk_gate_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(scan_tick) |-> $stable(gate_r))
      else $error("Gate changed away from a scan tick.");
   chk_gate_close_tick: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(gate_r) |-> $past(scan_tick))
      else $error("Gate closed between scan ticks.");
   chk_laser_in_gate: assert property (@(posedge pclk) disable iff (!presetn)
      gate_r |-> laser_en)
      else $error("Laser dark during an open gate.");
   chk_laser_poll_scan: assert property (@(posedge pclk) disable iff (!presetn)
      refl_mode && poll_scan && refl_r == RGT_RS_ARMED |-> laser_en)
      else $error("Laser dark on a polling scan.");
   chk_laser_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !refl_mode && !gate_r |-> !laser_en)
      else $error("Laser lit with no gate in sensor mode.");
   chk_scan_cnt_range: assert property (@(posedge pclk) disable iff (!presetn)
      scan_cnt_r <= RGT_POLL_LAST)
      else $error("Scan counter beyond the polling scan.");

   // Reflector sequence.
   chk_seen_before_arm: assert property (@(posedge pclk) disable iff (!presetn)
      refl_r != RGT_RS_UNSEEN |-> seen_once_r)
      else $error("Polling armed without a sighting.");
   chk_refl_gate_open: assert property (@(posedge pclk) disable iff (!presetn)
      refl_r == RGT_RS_GATE |-> gate_r)
      else $error("Reflector gate state with gate closed.");
   chk_gate_count: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(gate_r) |-> gates_r == $past(gates_r) + 16'h0001)
      else $error("Gate opening not counted.");

   // Power-up, results and registers.
   chk_gate_unready: assert property (@(posedge pclk) disable iff (!presetn)
      !ready |-> !gate_r)
      else $error("Gate open before ready.");
   chk_beep_unready: assert property (@(posedge pclk) disable iff (!presetn)
      beep |-> !ready)
      else $error("Tone sounding while ready.");
   chk_result_in_gate: assert property (@(posedge pclk) disable iff (!presetn)
      result_valid_r |-> $past(gate_r))
      else $error("Result reported outside a gate.");
   chk_result_data: assert property (@(posedge pclk) disable iff (!presetn)
      result_valid_r |-> result_data_r == $past(decode_data))
      else $error("Result data differs from the decoder.");
   chk_mode_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(wr_access && paddr == RGT_ADDR_CTRL) |-> $stable(mode_r))
      else $error("Trigger mode changed without a write.");
   chk_write_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
      wr_access && paddr == RGT_ADDR_CTRL |=> mode_r == $past(pwdata[RGT_CTRL_MODE_LSB +: 2]))
      else $error("Trigger mode write lost.");
   chk_mirror_parked: assert property (@(posedge pclk) disable iff (!presetn)
      !osc_en_r |=> mirror_angle_position == RGT_MIRROR_CENTER)
      else $error("Mirror not parked at centre with oscillation off.");
   // An unmapped address must be reported, since its write is silently dropped.
   chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable |-> pslverr == !addr_known(paddr))
      else $error("Error response does not match the address.");
   chk_err_access: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> psel && penable)
      else $error("Error response outside an access.");

   cov_sensor_gate: cover property (@(posedge pclk) disable iff (!presetn) $rose(gate_r) && mode_r == RGT_MODE_SENSOR);
   cov_refl_open: cover property (@(posedge pclk) disable iff (!presetn) $rose(gate_r) && refl_mode);
   cov_refl_close: cover property (@(posedge pclk) disable iff (!presetn) $fell(gate_r) && refl_mode);
   cov_refl_recheck: cover property (@(posedge pclk) disable iff (!presetn)
      refl_r == RGT_RS_ARMED && scan_tick && poll_scan && target_seen);
   cov_ready: cover property (@(posedge pclk) disable iff (!presetn) $rose(ready));
endmodule // rgt_trigger
`default_nettype wire

/* tb/rgt_field_model.sv */
// Model of the scan timing and of the polling target seen by the scanner.
`timescale 1ns/1ps
`default_nettype none
module rgt_field_model
#(
   parameter int unsigned SCAN_CYC = 20
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic laser_en,
   input wire logic target_present,
   output logic scan_tick,
   output logic target_seen
);
   logic [7:0] scan_cnt_r;
   logic filler_r;
   // The polygon motor runs free, so scan ticks never stop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scan_cnt_r <= 8'h00;
         scan_tick <= 1'b0;
         filler_r <= 1'b0;
      end
      else
      begin
         scan_cnt_r <= (scan_cnt_r == 8'(SCAN_CYC - 1)) ? 8'h00 : scan_cnt_r + 8'h01;
         scan_tick <= (scan_cnt_r == 8'(SCAN_CYC - 2));
         filler_r <= ~filler_r;
      end
   end
   // Off the tick the answer is not valid, so it toggles instead of holding a stale value.
   assign target_seen = scan_tick ? (target_present & laser_en) : filler_r;
endmodule // rgt_field_model
`default_nettype wire

/* tb/reading_gate_trigger_test.sv */
// Self-checking testbench of the reading gate trigger.
`timescale 1ns/1ps
`default_nettype none
module reading_gate_trigger_test;
   import rgt_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, selftest_pass, sensor1_in;
   logic decode_valid, decode_is_target, target_present, pready, pslverr, scan_tick, target_seen;
   logic reading_gate, laser_en, result_valid, beep, ready_led, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, decode_data, result_data, rd;
   logic [7:0] mirror_angle_position, lo, hi;
   logic gate_prev = 1'b0;
   logic tick_prev = 1'b0;
   logic saw_gate = 1'b0;
   logic beep_d = 1'b0;
   int failures = 0;
   int samples_checked = 0;
   int n, k;

   rgt_trigger #(.OSC_PERIOD_CYC(800), .TONE_CYC(10)) rgt_trigger_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .selftest_pass(selftest_pass), .scan_tick(scan_tick),
      .sensor1_in(sensor1_in), .target_seen(target_seen), .decode_valid(decode_valid),
      .decode_is_target(decode_is_target), .decode_data(decode_data), .reading_gate(reading_gate),
      .laser_en(laser_en), .result_valid(result_valid), .result_data(result_data), .beep(beep),
      .ready_led(ready_led), .mirror_angle_position(mirror_angle_position));
   rgt_field_model #(.SCAN_CYC(20)) rgt_field_model_inst (.pclk(pclk), .presetn(presetn),
      .laser_en(laser_en), .target_present(target_present), .scan_tick(scan_tick), .target_seen(target_seen));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done;
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_gate(input logic exp, input int bound);
      n = 0;
      while (reading_gate !== exp && n < bound)
      begin
         @(negedge pclk iff scan_tick === 1'b1);
         @(negedge pclk);
         n++;
      end
   endtask

   task automatic scan_run(input int cnt);
      k = 0;
      repeat (cnt)
      begin
         @(negedge pclk iff scan_tick === 1'b1);
         if (laser_en === 1'b1)
            k++;
      end
   endtask

   task automatic decode(input logic tgt, input logic [31:0] d, input logic exp);
      logic got = 1'b0;
      logic [31:0] gd = 32'h00000000;
      @(posedge pclk);
      decode_valid <= 1'b1;
      decode_is_target <= tgt;
      decode_data <= d;
      @(posedge pclk);
      decode_valid <= 1'b0;
      repeat (4)
      begin
         @(negedge pclk);
         if (result_valid === 1'b1)
         begin
            got = 1'b1;
            gd = result_data;
         end
      end
      check({31'h0, got}, {31'h0, exp}, "result pulse");
      if (exp)
         check(gd, d, "result data");
   endtask

   // Sampling on the falling edge keeps the gate monitor clear of update races.
   always @(negedge pclk)
   begin
      if (presetn === 1'b1 && reading_gate !== gate_prev && tick_prev !== 1'b1)
      begin
         failures++;
         $display("MISMATCH %0t gate moved between scan ticks", $time);
      end
      if (reading_gate === 1'b1)
         saw_gate = 1'b1;
      gate_prev = reading_gate;
      tick_prev = scan_tick;
   end

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial
   begin
      #200000;
      failures++;
      test_done;
   end

   initial
   begin
      {presetn, psel, penable, pwrite, selftest_pass, sensor1_in} = 6'h00;
      {decode_valid, decode_is_target, target_present} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      decode_data = 32'h00000000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, RGT_ADDR_CTRL, 32'h00000000);
      check(rd, 32'h00000004, "ctrl reset");
      apb(1'b0, 12'h00C, 32'h00000000);
      check({rd[30:0], err}, 32'h00000001, "unmapped read");
      selftest_pass <= 1'b1;
      k = 0;
      for (n = 0; n < 300 && ready_led !== 1'b1; n++)
      begin
         @(negedge pclk);
         if (beep === 1'b1 && beep_d !== 1'b1)
            k++;
         beep_d = beep;
      end
      check(32'(k), 32'h00000003, "tone count");
      check({31'h0, ready_led}, 32'h00000001, "ready indicator");
      lo = 8'hFF;
      hi = 8'h00;
      repeat (1000)
      begin
         @(negedge pclk);
         if (mirror_angle_position < lo)
            lo = mirror_angle_position;
         if (mirror_angle_position > hi)
            hi = mirror_angle_position;
      end
      check({24'h0, lo}, 32'h0000001E, "mirror low end");
      check({24'h0, hi}, 32'h00000046, "mirror high end");
      @(posedge pclk);
      sensor1_in <= 1'b1;
      wait_gate(1'b1, 2);
      check({31'h0, reading_gate}, 32'h00000001, "sensor opens gate");
      decode(1'b1, 32'hA5A5A5A5, 1'b0);
      decode(1'b0, 32'h1234ABCD, 1'b1);
      @(posedge pclk);
      sensor1_in <= 1'b0;
      wait_gate(1'b0, 2);
      check({31'h0, reading_gate}, 32'h00000000, "sensor closes gate");
      apb(1'b1, RGT_ADDR_CTRL, 32'h00000001);
      sensor1_in <= 1'b1;
      saw_gate = 1'b0;
      scan_run(40);
      check({31'h0, saw_gate}, 32'h00000000, "no gate before target seen");
      check(32'(k), 32'h00000002, "polling scans");
      @(posedge pclk);
      target_present <= 1'b1;
      scan_run(40);
      check({31'h0, saw_gate}, 32'h00000000, "gate with target visible");
      check(32'(k), 32'h00000002, "repeat after 20 scans");
      @(posedge pclk);
      target_present <= 1'b0;
      wait_gate(1'b1, 30);
      check({31'h0, reading_gate}, 32'h00000001, "hidden target opens gate");
      check((n <= int'(RGT_POLL_DELAY_SCANS) + 1) ? 32'h1 : 32'h0, 32'h00000001, "open delay");
      @(posedge pclk);
      target_present <= 1'b1;
      wait_gate(1'b0, 2);
      check({31'h0, reading_gate}, 32'h00000000, "target back closes gate");
      @(posedge pclk);
      target_present <= 1'b0;
      wait_gate(1'b1, 30);
      check({31'h0, reading_gate}, 32'h00000001, "polling resumed");
      apb(1'b0, RGT_ADDR_STATUS, 32'h00000000);
      check(rd, 32'h00000657, "status word");
      check({31'h0, err}, 32'h00000000, "status no error");
      apb(1'b0, RGT_ADDR_GATES, 32'h00000000);
      check(rd, 32'h00000003, "gate openings");
      test_done;
   end
endmodule // reading_gate_trigger_test
`default_nettype wire
